// >>> mmphy_mgmt.v
// Management serial master with APB registers and transceiver controls
// Notes on behaviour
// - Management clock is bus clock over 2xdivider, over 2 when divider is zero
// - Five-bit PHY address selects target PHY
// - Five-bit register address selects PHY register
// - Read value valid once done flag set
// - Command two while idle starts read
// - Read end: busy clears, data loads, done
// - Command one while idle starts write
// - Write end: busy clears, done flag set
// - PHY registers reachable only through frames
// - Bit 7 enables transceiver, resets clear
// - Control one holds address, upper bits zero
// - Two clock-generation off bits reset set
// - Bit 6 autoneg disable resets set
// - Bit 3 indicator enable resets clear
// - Bit 0 interrupt enable resets clear
`timescale 1ns/100ps
`include "mmphy_defs.vh"
module mmphy_mgmt
(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   output reg         mdc,
   output reg         mdio_o,
   output reg         mdio_oe_n,
   input  wire        mdio_i,
   output reg         transceiver_enable,
   output reg         autoneg_disable,
   output reg         fast_clock_gen_off,
   output reg         slow_clock_gen_off,
   output reg         indicator_lamp_enable,
   output reg         transceiver_irq_enable,
   output reg  [4:0]  transceiver_address
);
   reg  [6:0]  div_q;
   reg  [4:0]  phy_addr_q;
   reg  [4:0]  reg_addr_q;
   reg  [15:0] wr_val_q;
   reg  [15:0] rd_val_q;
   reg         busy_q;
   reg         done_flag_q;
   reg  [7:0]  xctl0_q;
   reg  [4:0]  xctl1_q;
   reg         start_q;
   reg         rd_kind_q;
   reg         mdio_m_q;
   reg         mdio_s_q;
   reg  [31:0] rdata_d;
   reg         hit_d;
   wire        setup  = psel && !penable;
   wire        wr_acc = setup && pwrite;
   wire        rd_acc = setup && !pwrite;
   wire        eng_active;
   wire        eng_done;
   wire [15:0] eng_rd_val;
   wire        mdc_w;
   wire        rise_w;
   wire        fall_w;
   wire        mdio_o_w;
   wire        mdio_oe_n_w;
   wire [1:0]  cmd_w  = pwdata[`MMPHY_CMD_MSB:`MMPHY_CMD_LSB];
   wire        launch = wr_acc && (paddr == `MMPHY_OFF_CMD_STAT) && !busy_q
                        && (cmd_w == `MMPHY_OP_WRITE || cmd_w == `MMPHY_OP_READ);

   function mapped;
      input [11:0] a;
      begin
         mapped = (a == `MMPHY_OFF_CMD_STAT) || (a == `MMPHY_OFF_PHY_ADDR) ||
                  (a == `MMPHY_OFF_REG_ADDR) || (a == `MMPHY_OFF_WR_VAL) ||
                  (a == `MMPHY_OFF_RD_VAL) || (a == `MMPHY_OFF_EVENT) ||
                  (a == `MMPHY_OFF_XCTL0) || (a == `MMPHY_OFF_XCTL1);
      end
   endfunction

   // Read mux; PHY's own registers never appear here
   always @*
   begin
      rdata_d = 32'h00000000;
      hit_d   = mapped(paddr);
      case (paddr)
         `MMPHY_OFF_CMD_STAT:
         begin
            rdata_d[`MMPHY_DIV_MSB:`MMPHY_DIV_LSB] = div_q;
            rdata_d[`MMPHY_BUSY_BIT]               = busy_q;
         end
         `MMPHY_OFF_PHY_ADDR: rdata_d[4:0]  = phy_addr_q;
         `MMPHY_OFF_REG_ADDR: rdata_d[4:0]  = reg_addr_q;
         `MMPHY_OFF_WR_VAL:   rdata_d[15:0] = wr_val_q;
         `MMPHY_OFF_RD_VAL:   rdata_d[15:0] = rd_val_q;
         `MMPHY_OFF_EVENT:    rdata_d[`MMPHY_DONE_BIT] = done_flag_q;
         `MMPHY_OFF_XCTL0:    rdata_d[7:0]  = xctl0_q;
         `MMPHY_OFF_XCTL1:    rdata_d[4:0]  = xctl1_q;
         default:             rdata_d = 32'h00000000;
      endcase
   end

   // No wait state: answer in the first access-phase cycle after setup
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= setup;
         pslverr <= setup && !hit_d;
         prdata  <= rd_acc ? rdata_d : 32'h00000000;
      end
   end

   // Software registers
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_q      <= `MMPHY_DIV_RST;
         phy_addr_q <= 5'h00;
         reg_addr_q <= 5'h00;
         wr_val_q   <= 16'h0000;
         xctl0_q    <= `MMPHY_XCTL0_RST;
         xctl1_q    <= 5'h00;
      end
      else if (wr_acc)
      begin
         case (paddr)
            `MMPHY_OFF_CMD_STAT:
               // Divider frozen while busy so a running frame keeps its timing
               if (!busy_q)
                  div_q <= pwdata[`MMPHY_DIV_MSB:`MMPHY_DIV_LSB];
            `MMPHY_OFF_PHY_ADDR: phy_addr_q <= pwdata[4:0];
            `MMPHY_OFF_REG_ADDR: reg_addr_q <= pwdata[4:0];
            `MMPHY_OFF_WR_VAL:   wr_val_q   <= pwdata[15:0];
            `MMPHY_OFF_XCTL0:    xctl0_q    <= pwdata[7:0] & `MMPHY_XCTL0_WMASK;
            `MMPHY_OFF_XCTL1:    xctl1_q    <= pwdata[4:0];
            default:             div_q      <= div_q;
         endcase
      end
   end

   // Busy, launch and completion; done set wins over a clear in the same cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         busy_q      <= 1'b0;
         start_q     <= 1'b0;
         rd_kind_q   <= 1'b0;
         done_flag_q <= 1'b0;
         rd_val_q    <= 16'h0000;
      end
      else
      begin
         start_q <= launch;
         if (launch)
         begin
            busy_q    <= 1'b1;
            rd_kind_q <= (cmd_w == `MMPHY_OP_READ);
         end
         else if (eng_done)
            busy_q <= 1'b0;
         if (eng_done && rd_kind_q)
            rd_val_q <= eng_rd_val;
         if (eng_done)
            done_flag_q <= 1'b1;
         else if (wr_acc && paddr == `MMPHY_OFF_EVENT && pwdata[`MMPHY_DONE_BIT])
            done_flag_q <= 1'b0;
      end
   end

   // MDIO input comes from a pin: two flops before use
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mdio_m_q <= 1'b1;
         mdio_s_q <= 1'b1;
      end
      else
      begin
         mdio_m_q <= mdio_i;
         mdio_s_q <= mdio_m_q;
      end
   end

   mmphy_clkdiv u_div
   (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (busy_q),
      .div_sel (div_q),
      .mdc_q   (mdc_w),
      .rise_q  (rise_w),
      .fall_q  (fall_w)
   );

   mmphy_frame u_frame
   (
      .pclk        (pclk),
      .presetn     (presetn),
      .start       (start_q),
      .is_read     (rd_kind_q),
      .phy_addr    (phy_addr_q),
      .reg_addr    (reg_addr_q),
      .wr_val      (wr_val_q),
      .mdc_rise    (rise_w),
      .mdc_fall    (fall_w),
      .mdio_in_s   (mdio_s_q),
      .active_q    (eng_active),
      .done_q      (eng_done),
      .rd_val_q    (eng_rd_val),
      .mdio_o_q    (mdio_o_w),
      .mdio_oe_n_q (mdio_oe_n_w)
   );

   // Outputs re-registered so every top output is a flop; costs one cycle of skew
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mdc                    <= 1'b0;
         mdio_o                 <= 1'b1;
         mdio_oe_n              <= 1'b1;
         transceiver_enable     <= 1'b0;
         autoneg_disable        <= 1'b1;
         fast_clock_gen_off     <= 1'b1;
         slow_clock_gen_off     <= 1'b1;
         indicator_lamp_enable  <= 1'b0;
         transceiver_irq_enable <= 1'b0;
         transceiver_address    <= 5'h00;
      end
      else
      begin
         mdc                    <= mdc_w && eng_active;
         mdio_o                 <= mdio_o_w;
         mdio_oe_n              <= mdio_oe_n_w;
         transceiver_enable     <= xctl0_q[7];
         autoneg_disable        <= xctl0_q[6];
         fast_clock_gen_off     <= xctl0_q[5];
         slow_clock_gen_off     <= xctl0_q[4];
         indicator_lamp_enable  <= xctl0_q[3];
         transceiver_irq_enable <= xctl0_q[0];
         transceiver_address    <= xctl1_q;
      end
   end
endmodule

// >>> mmphy_defs.vh
// Register map, field positions, reset values and frame constants
`ifndef MMPHY_DEFS_VH
`define MMPHY_DEFS_VH
`define MMPHY_OFF_CMD_STAT 12'h000
`define MMPHY_OFF_PHY_ADDR 12'h004
`define MMPHY_OFF_REG_ADDR 12'h008
`define MMPHY_OFF_WR_VAL   12'h00c
`define MMPHY_OFF_RD_VAL   12'h010
`define MMPHY_OFF_EVENT    12'h014
`define MMPHY_OFF_XCTL0    12'h018
`define MMPHY_OFF_XCTL1    12'h01c
`define MMPHY_CMD_LSB      0
`define MMPHY_CMD_MSB      1
`define MMPHY_BUSY_BIT     7
`define MMPHY_DIV_LSB      8
`define MMPHY_DIV_MSB      14
`define MMPHY_DIV_RST      7'h05
`define MMPHY_OP_WRITE     2'h1
`define MMPHY_OP_READ      2'h2
`define MMPHY_DONE_BIT     0
`define MMPHY_XCTL0_RST    8'h70
`define MMPHY_XCTL0_WMASK  8'hf9
`define MMPHY_XCTL1_RST    8'h00
`define MMPHY_XCTL1_WMASK  8'h1f
`define MMPHY_FRAME_BITS   7'd64
`define MMPHY_TA_FIRST     7'd46
`define MMPHY_DATA_FIRST   7'd48
`endif

// >>> mmphy_clkdiv.v
// Management clock divider producing half-period ticks
`timescale 1ns/100ps
`include "mmphy_defs.vh"
module mmphy_clkdiv
(
   input  wire       pclk,
   input  wire       presetn,
   input  wire       run,
   input  wire [6:0] div_sel,
   output reg        mdc_q,
   output reg        rise_q,
   output reg        fall_q
);
   reg  [6:0] cnt_q;
   wire [6:0] lim = (div_sel == 7'h00) ? 7'h01 : div_sel;
   // Each half period lasts div_sel bus clocks (one if div_sel is zero), so period is twice that
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q  <= 7'h00;
         mdc_q  <= 1'b0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end
      else if (!run)
      begin
         cnt_q  <= 7'h00;
         mdc_q  <= 1'b0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end
      else if (cnt_q + 7'h01 >= lim)
      begin
         cnt_q  <= 7'h00;
         mdc_q  <= ~mdc_q;
         rise_q <= ~mdc_q;
         fall_q <= mdc_q;
      end
      else
      begin
         cnt_q  <= cnt_q + 7'h01;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end
   end
endmodule

// >>> mmphy_frame.v
// Management frame shifter: preamble, start, opcode, addresses, turnaround, data
`timescale 1ns/100ps
`include "mmphy_defs.vh"
module mmphy_frame
(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        start,
   input  wire        is_read,
   input  wire [4:0]  phy_addr,
   input  wire [4:0]  reg_addr,
   input  wire [15:0] wr_val,
   input  wire        mdc_rise,
   input  wire        mdc_fall,
   input  wire        mdio_in_s,
   output reg         active_q,
   output reg         done_q,
   output reg  [15:0] rd_val_q,
   output reg         mdio_o_q,
   output reg         mdio_oe_n_q
);
   reg [6:0]  bit_q;
   reg [63:0] shift_q;
   reg        rd_q;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bit_q       <= 7'd0;
         shift_q     <= 64'h0;
         rd_q        <= 1'b0;
         active_q    <= 1'b0;
         done_q      <= 1'b0;
         rd_val_q    <= 16'h0000;
         mdio_o_q    <= 1'b1;
         mdio_oe_n_q <= 1'b1;
      end
      else
      begin
         done_q <= 1'b0;
         if (start && !active_q)
         begin
            // 32 ones, 01, opcode, addresses, 10 turnaround, data
            shift_q  <= {32'hffffffff, 2'b01, (is_read ? 2'b10 : 2'b01),
                         phy_addr, reg_addr, 2'b10, wr_val};
            rd_q     <= is_read;
            bit_q    <= 7'd0;
            active_q <= 1'b1;
         end
         else if (active_q && mdc_fall)
         begin
            if (bit_q == `MMPHY_FRAME_BITS)
            begin
               active_q    <= 1'b0;
               done_q      <= 1'b1;
               mdio_oe_n_q <= 1'b1;
               mdio_o_q    <= 1'b1;
            end
            else
            begin
               mdio_o_q    <= shift_q[63];
               shift_q     <= {shift_q[62:0], 1'b0};
               // Released from turnaround onward on reads
               mdio_oe_n_q <= rd_q && (bit_q >= `MMPHY_TA_FIRST);
               bit_q       <= bit_q + 7'd1;
            end
         end
         else if (active_q && mdc_rise && rd_q && (bit_q > `MMPHY_DATA_FIRST))
         begin
            // PHY drives data after a falling edge; sample on rising edge
            rd_val_q <= {rd_val_q[14:0], mdio_in_s};
         end
      end
   end
endmodule

// >>> mmphy_monitor.sv
// Port assertions for the management master, bound to its top module
`timescale 1ns/100ps
`include "mmphy_defs.vh"
module mmphy_monitor
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        mdc,
   input wire logic        mdio_o,
   input wire logic        mdio_oe_n,
   input wire logic        transceiver_enable,
   input wire logic        autoneg_disable,
   input wire logic        fast_clock_gen_off,
   input wire logic        slow_clock_gen_off,
   input wire logic        indicator_lamp_enable,
   input wire logic        transceiver_irq_enable,
   input wire logic [4:0]  transceiver_address
);
   logic [3:0] quiet_q;
   logic [6:0] rises_q;
   logic       mdc_q;
   wire        set_w  = psel && !penable && pwrite;
   wire        cmd_w  = set_w && paddr == `MMPHY_OFF_CMD_STAT;
   wire        idle_w = quiet_q == 4'hf;
   wire [5:0]  c0_w   = {pwdata[7:3], pwdata[0]};
   wire [4:0]  c1_w   = pwdata[4:0];
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Quiet for 15 cycles means idle; only valid while the divider stays small
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         quiet_q <= 4'h0;
         rises_q <= 7'h0;
         mdc_q   <= 1'b0;
      end
      else
      begin
         mdc_q   <= mdc;
         quiet_q <= (mdc != mdc_q) ? 4'h0 : quiet_q + {3'h0, !idle_w};
         rises_q <= idle_w ? 7'h0 : rises_q + {6'h0, mdc && !mdc_q};
      end
   end
   AST_READY: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   AST_UNMAPPED: assert property (
      psel && penable && pready && paddr > `MMPHY_OFF_XCTL1 |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   AST_CTL0: assert property (
      set_w && paddr == `MMPHY_OFF_XCTL0 |-> ##2 $past(c0_w, 2) == {transceiver_enable,
      autoneg_disable, fast_clock_gen_off, slow_clock_gen_off, indicator_lamp_enable,
      transceiver_irq_enable}) else $error("control zero outputs wrong");
   AST_CTL1: assert property (
      set_w && paddr == `MMPHY_OFF_XCTL1 |-> ##2 transceiver_address == $past(c1_w, 2))
      else $error("address output wrong");
   AST_HIGH: assert property ($rose(mdc) |=> $stable(mdc) [*4] ##1 $fell(mdc))
      else $error("mdc high phase wrong");
   AST_LOW: assert property ($fell(mdc) |=> $stable(mdc) [*4])
      else $error("mdc low phase short");
   AST_EDGE: assert property ($changed(mdio_o) && !mdio_oe_n |-> !mdc)
      else $error("mdio moved while mdc high");
   AST_TA: assert property ($rose(mdio_oe_n) |-> rises_q == 7'd46 || rises_q == 7'd64)
      else $error("mdio released at wrong bit");
   AST_START: assert property (
      cmd_w && idle_w && (pwdata[1:0] == 2'h1 || pwdata[1:0] == 2'h2) |-> ##[1:40] $rose(mdc))
      else $error("frame did not start");
   AST_NOSTART: assert property (
      cmd_w && idle_w && (pwdata[1:0] == 2'h0 || pwdata[1:0] == 2'h3) |=> $stable(mdc) [*8])
      else $error("frame started without command");
   cover property (cmd_w && idle_w);
   cover property ($rose(mdio_oe_n) && rises_q == 7'd46);
   cover property (pslverr && pready);
endmodule
bind mmphy_mgmt mmphy_monitor i_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .mdc, .mdio_o, .mdio_oe_n, .transceiver_enable,
   .autoneg_disable, .fast_clock_gen_off, .slow_clock_gen_off, .indicator_lamp_enable,
   .transceiver_irq_enable, .transceiver_address);

// >>> mmphy_phy_model.sv
// Behavioural PHY answering management frames on a pulled-up data line
`timescale 1ns/100ps
module mmphy_phy_model
#(
   parameter [4:0] OWN_ADDR = 5'h0b
)
(
   input  wire logic        presetn,
   input  wire logic        mdc,
   input  wire logic        mdio_o,
   input  wire logic        mdio_oe_n,
   output wire logic        mdio_i,
   output logic      [63:0] last_frame,
   output logic      [7:0]  frames
);
   logic [15:0] regs [0:31];
   logic [63:0] sr;
   logic [6:0]  cnt;
   logic [4:0]  ra;
   logic        rd_hit;
   logic        in_frame;
   logic        drv;
   logic        bit_v;
   integer      i;
   // Released line floats to one; contention resolves low
   assign mdio_i = (mdio_oe_n ? 1'b1 : mdio_o) & (drv ? bit_v : 1'b1);
   always @(posedge mdc or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt = 7'd0;
         in_frame = 1'b0;
         rd_hit = 1'b0;
         frames = 8'h0;
         last_frame = 64'h0;
         for (i = 0; i < 32; i = i + 1)
            regs[i] = {3'h0, i[4:0], 8'h3c};
      end
      else
      begin
         sr = {sr[62:0], mdio_i};
         // Extra preamble clocks are legal, so lock on to the start pattern
         if (!in_frame)
         begin
            if (sr[33:0] == {32'hffffffff, 2'b01})
            begin
               in_frame = 1'b1;
               cnt = 7'd34;
            end
         end
         else
         begin
            if (cnt == 7'd45)
            begin
               ra = sr[4:0];
               rd_hit = sr[11:10] == 2'b10 && sr[9:5] == OWN_ADDR;
            end
            if (cnt == 7'd63)
            begin
               if (sr[29:28] == 2'b01 && sr[27:23] == OWN_ADDR)
                  regs[sr[22:18]] = sr[15:0];
               last_frame = sr;
               frames = frames + 8'h1;
               rd_hit = 1'b0;
               in_frame = 1'b0;
               cnt = 7'd0;
            end
            else
               cnt = cnt + 7'd1;
         end
      end
   end
   // Changing on the falling edge keeps data steady around the sampling rise
   always @(negedge mdc or negedge presetn)
   begin
      if (!presetn)
         drv = 1'b0;
      else
      begin
         drv = rd_hit && cnt >= 7'd47;
         bit_v = (cnt == 7'd47) ? 1'b0 : regs[ra][63 - cnt];
      end
   end
endmodule

// >>> mii_mgmt_master_phy_ctrl_tb.sv
// Self-checking bench: register rows, then frames against the PHY model
`timescale 1ns/100ps
`include "mmphy_defs.vh"
`define MMPHY_CHK(g, e) \
   begin \
      tests_run = tests_run + 1; \
      if ((g) !== (e)) \
      begin \
         fails = fails + 1; \
         $display("BAD %0t got %0h want %0h", $time, (g), (e)); \
      end \
   end
module mii_mgmt_master_phy_ctrl_tb;
   typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] e; logic r;} mmphy_row_t;
   localparam [4:0] PHY_AD = 5'h0b;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   wire  [31:0] prdata;
   wire         pready, pslverr, mdc, mdio_o, mdio_oe_n, mdio_i;
   wire  [63:0] last_frame;
   wire  [7:0]  frames;
   logic [31:0] rd_v;
   logic        err_v;
   logic [7:0]  nf;
   integer      fails = 0;
   integer      tests_run = 0;
   integer      k;
   mmphy_row_t  rows [0:6];
   mmphy_mgmt i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .mdc, .mdio_o, .mdio_oe_n, .mdio_i, .transceiver_enable(),
      .autoneg_disable(), .fast_clock_gen_off(), .slow_clock_gen_off(),
      .indicator_lamp_enable(), .transceiver_irq_enable(), .transceiver_address());
   mmphy_phy_model #(.OWN_ADDR(PHY_AD)) i_phy (.presetn, .mdc, .mdio_o, .mdio_oe_n,
      .mdio_i, .last_frame, .frames);
   always #12.5 pclk = ~pclk;
   task give_verdict;
      begin
         if (fails == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      integer n;
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         n = 0;
         do
         begin
            @(posedge pclk);
            n = n + 1;
         end
         while (pready !== 1'b1 && n < 20);
         if (pready !== 1'b1)
            fails = fails + 1;
         rd_v = prdata;
         err_v = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task chk_reset;
      begin
         apb(1'b0, `MMPHY_OFF_XCTL0, 32'h0);
         `MMPHY_CHK(rd_v, 32'h70)
         apb(1'b0, `MMPHY_OFF_XCTL1, 32'h0);
         `MMPHY_CHK(rd_v, 32'h0)
         apb(1'b0, `MMPHY_OFF_CMD_STAT, 32'h0);
         `MMPHY_CHK(rd_v, 32'h500)
      end
   endtask
   // A second, opposite command with another divider comes while busy and must be dropped
   task frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
              input logic [15:0] wv, input logic [17:0] tail);
      begin
         nf = frames;
         apb(1'b1, `MMPHY_OFF_PHY_ADDR, {27'h0, pa});
         apb(1'b1, `MMPHY_OFF_REG_ADDR, {27'h0, ra});
         apb(1'b1, `MMPHY_OFF_WR_VAL, {16'h0, wv});
         apb(1'b1, `MMPHY_OFF_CMD_STAT, {24'h5, 6'h0, op});
         apb(1'b1, `MMPHY_OFF_CMD_STAT, {24'h7, 6'h0, ~op});
         k = 0;
         do
         begin
            apb(1'b0, `MMPHY_OFF_CMD_STAT, 32'h0);
            k = k + 1;
         end
         while (rd_v[7] === 1'b1 && k < 400);
         `MMPHY_CHK(rd_v, 32'h500)
         `MMPHY_CHK(k > 1, 1'b1)
         `MMPHY_CHK(frames, nf + 8'h1)
         `MMPHY_CHK(last_frame, {32'hffffffff, 2'b01, op, pa, ra, tail})
         apb(1'b0, `MMPHY_OFF_EVENT, 32'h0);
         `MMPHY_CHK(rd_v, 32'h1)
         apb(1'b1, `MMPHY_OFF_EVENT, 32'h1);
         apb(1'b0, `MMPHY_OFF_RD_VAL, 32'h0);
         if (op == 2'h2)
            `MMPHY_CHK(rd_v, {16'h0, tail[15:0]})
      end
   endtask
   initial
   begin
      repeat (20000) @(posedge pclk);
      fails = fails + 1;
      give_verdict;
   end
   initial
   begin
      rows[0] = '{`MMPHY_OFF_XCTL1, 32'hff, 32'h1f, 1'b0};
      rows[1] = '{`MMPHY_OFF_XCTL0, 32'h0, 32'h0, 1'b0};
      rows[2] = '{`MMPHY_OFF_XCTL0, 32'hff, 32'hf9, 1'b0};
      rows[3] = '{`MMPHY_OFF_PHY_ADDR, 32'hffffffff, 32'h1f, 1'b0};
      rows[4] = '{`MMPHY_OFF_REG_ADDR, 32'hffffffff, 32'h1f, 1'b0};
      rows[5] = '{`MMPHY_OFF_WR_VAL, 32'hffffffff, 32'hffff, 1'b0};
      rows[6] = '{12'h020, 32'hffffffff, 32'h0, 1'b1};
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      chk_reset;
      for (k = 0; k < 7; k = k + 1)
      begin
         apb(1'b1, rows[k].a, rows[k].d);
         apb(1'b0, rows[k].a, 32'h0);
         `MMPHY_CHK({err_v, rd_v}, {rows[k].r, rows[k].e})
      end
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk_reset;
      frame(2'h1, PHY_AD, 5'h1f, 16'ha5c3, {2'b10, 16'ha5c3});
      frame(2'h2, PHY_AD, 5'h1f, 16'h0, {2'b10, 16'ha5c3});
      frame(2'h2, PHY_AD, 5'h00, 16'h0, {2'b10, 16'h003c});
      frame(2'h2, 5'h0a, 5'h1f, 16'h0, {2'b11, 16'hffff});
      // Let the line go quiet so the no-start check sees an idle master
      repeat (16) @(posedge pclk);
      apb(1'b1, `MMPHY_OFF_CMD_STAT, 32'h503);
      apb(1'b0, `MMPHY_OFF_CMD_STAT, 32'h0);
      `MMPHY_CHK(rd_v, 32'h500)
      give_verdict;
   end
endmodule
